// ### rtl/scrs_defines.svh
// Register offsets, field positions, reset values and counts of the serial
// clock and receive-sampling front end.
// Assumes inclusion by bare name from the design files.
`ifndef SCRS_DEFINES_SVH
`define SCRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SCRS_ADDR_CTRL      8'h00
`define SCRS_ADDR_BRG       8'h04
`define SCRS_ADDR_TMR       8'h08
`define SCRS_ADDR_RXDATA    8'h0C
`define SCRS_ADDR_STATUS    8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCRS_CTRL_MODE_IO   0
`define SCRS_CTRL_CLKDIR    1
`define SCRS_CTRL_EDGE      2
`define SCRS_CTRL_SRC       4:3
`define SCRS_CTRL_TAP       6:5
`define SCRS_CTRL_RXEN      7
`define SCRS_BRG_N          3:0
`define SCRS_BRG_K          7:4
`define SCRS_BRG_FRACEN     8
`define SCRS_TMR_RELOAD     7:0
`define SCRS_TMR_TAP        9:8
`define SCRS_ST_DONE        0
`define SCRS_ST_FERR        1
`define SCRS_ST_OVR         2
`define SCRS_ST_BUSY        3
`define SCRS_ST_CNT         7:4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SCRS_CTRL_RST       8'h00
`define SCRS_BRG_RST        9'h001
`define SCRS_TMR_RST        10'h001

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
`define SCRS_N_ZERO_DIV     5'h10
`define SCRS_FRAC_BASE      5'h10
`define SCRS_PRE_DIV4       2'h3
`define SCRS_PRE_DIV16      4'hF
`define SCRS_PRE_DIV64      6'h3F
`define SCRS_SAMPLE_1ST     4'h7
`define SCRS_SAMPLE_2ND     4'h8
`define SCRS_SAMPLE_3RD     4'h9
`define SCRS_LAST_BIT       3'h7
`define SCRS_SRC_DIVIDER    2'h0
`define SCRS_SRC_HALF_SYS   2'h1
`define SCRS_SRC_TIMER      2'h2
`define SCRS_SRC_PIN        2'h3

`endif

// ### rtl/scrs_pkg.sv
// Types shared by the serial clock and receive-sampling front end.
// Assumes nothing of its surroundings.
package scrs_pkg;

  // Asynchronous receiver states, one-hot
  typedef enum logic [3:0] {
    SCRS_RX_IDLE  = 4'b0001,
    SCRS_RX_START = 4'b0010,
    SCRS_RX_DATA  = 4'b0100,
    SCRS_RX_STOP  = 4'b1000
  } scrs_rx_state_e;

endpackage

// ### rtl/scrs_top.sv
// Serial channel clock generation and receive sampling with an APB slave.
// Assumes an APB master on pclk and an external peer on the data/clock pins.
//
// How it works
// - External clock gives one sample per rising edge in UART; raw bit clock in I/O.
// - Divisor field value 1 to 15 divides by itself; zero divides by 16.
// - Timer source gives rate = tap frequency / (reload x 2 x 16).
// - I/O mode never takes the timer output as its clock.
// - I/O mode, direction 0: drive clock pin, divider output halved.
// - I/O mode, direction 1: clock pin is input, edge chosen by select bit.
// - UART source field picks divider, half sysclock, timer or clock pin.
// - UART receive timing uses a 4-bit up-counter on the sample clock.
// - Sixteen sample clocks per bit; vote majority of clocks 7, 8, 9.
// - I/O receive samples on driven rising edge or on selected input edge.
// - UART receiver samples data only after a valid start bit.
// - Fraction off: divide by integer N from 1 to 16, fraction ignored.
// - Fraction on: divide by N + (16-K)/16 for N 2 to 15.
// - Divider input is one of prescaler taps divide by 1, 4, 16, 64.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "scrs_defines.svh"

module scrs_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        receive_data_pin,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_n
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [8:0]  brg_reg;
  logic [9:0]  tmr_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        rxd_s1_reg, rxd_s2_reg, rxd_s3_reg;
  logic        sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic [5:0]  pre_cnt_reg;
  logic [4:0]  div_cnt_reg;
  logic [3:0]  frac_acc_reg;
  logic        extra_reg;
  logic        brg_tick_reg;
  logic        half_reg;
  logic [7:0]  tmr_cnt_reg;
  logic        tab_out_reg;
  logic        sck_out_reg;
  logic        sck_oe_n_reg;
  scrs_pkg::scrs_rx_state_e state_reg, state_next;
  logic [3:0]  rx_cnt_reg, rx_cnt_next;
  logic [1:0]  samp_reg, samp_next;
  logic [7:0]  shift_reg, shift_next;
  logic [2:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  data_reg;
  logic        done_reg, ferr_reg, ovr_reg;
  logic        frame_set;
  logic        frame_ferr;

  // --------------------------------------------------------------------------
  // Register fields
  // --------------------------------------------------------------------------
  wire       mode_io                  = ctrl_reg[`SCRS_CTRL_MODE_IO];
  wire       clock_direction_bit      = ctrl_reg[`SCRS_CTRL_CLKDIR];
  wire       clock_edge_select        = ctrl_reg[`SCRS_CTRL_EDGE];
  wire [1:0] uart_clock_source_select = ctrl_reg[`SCRS_CTRL_SRC];
  wire [1:0] brg_tap_select           = ctrl_reg[`SCRS_CTRL_TAP];
  wire       rx_enable                = ctrl_reg[`SCRS_CTRL_RXEN];
  wire [3:0] integer_divisor_field    = brg_reg[`SCRS_BRG_N];
  wire [3:0] fraction_field           = brg_reg[`SCRS_BRG_K];
  wire       fractional_divide_enable = brg_reg[`SCRS_BRG_FRACEN];
  wire [7:0] timer_reload_value       = tmr_reg[`SCRS_TMR_RELOAD];
  wire [1:0] prescaler_source_select  = tmr_reg[`SCRS_TMR_TAP];

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  wire apb_setup   = psel & penable & ~pready_reg;
  wire apb_done    = psel & penable & pready_reg;
  wire hit_ctrl    = (paddr == `SCRS_ADDR_CTRL);
  wire hit_brg     = (paddr == `SCRS_ADDR_BRG);
  wire hit_tmr     = (paddr == `SCRS_ADDR_TMR);
  wire hit_rxdata  = (paddr == `SCRS_ADDR_RXDATA);
  wire hit_status  = (paddr == `SCRS_ADDR_STATUS);
  wire addr_ok     = hit_ctrl | hit_brg | hit_tmr | hit_rxdata | hit_status;
  wire wr_en       = apb_done & pwrite & addr_ok;
  wire rd_data_clr = apb_done & ~pwrite & hit_rxdata;
  wire rd_stat_clr = apb_done & ~pwrite & hit_status;
  wire busy        = (state_reg != scrs_pkg::SCRS_RX_IDLE) | (bit_cnt_reg != 3'h0);
  wire [7:0] status_word = {rx_cnt_reg, busy, ovr_reg, ferr_reg, done_reg};
  wire [31:0] rd_mux = hit_ctrl   ? {24'h0, ctrl_reg} :
                       hit_brg    ? {23'h0, brg_reg} :
                       hit_tmr    ? {22'h0, tmr_reg} :
                       hit_rxdata ? {24'h0, data_reg} :
                       hit_status ? {24'h0, status_word} : 32'h0;

  // One wait state: ready rises the cycle after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~addr_ok;
      if (apb_setup & ~pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SCRS_CTRL_RST;
      brg_reg  <= `SCRS_BRG_RST;
      tmr_reg  <= `SCRS_TMR_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= pwdata[7:0];
      if (hit_brg)  brg_reg  <= pwdata[8:0];
      if (hit_tmr)  tmr_reg  <= pwdata[9:0];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // --------------------------------------------------------------------------
  // Pin synchronisers (third stage is the edge-detect history)
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rxd_s1_reg, rxd_s2_reg, rxd_s3_reg} <= 3'h7;
      {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= 3'h7;
    end else begin
      {rxd_s1_reg, rxd_s2_reg, rxd_s3_reg} <= {receive_data_pin, rxd_s1_reg, rxd_s2_reg};
      {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= {serial_clock_pin_i, sck_s1_reg, sck_s2_reg};
    end
  end

  wire rxd     = rxd_s2_reg;
  wire rxd_fall = ~rxd_s2_reg & rxd_s3_reg;
  wire sck_rise = sck_s2_reg & ~sck_s3_reg;
  wire sck_fall = ~sck_s2_reg & sck_s3_reg;

  // --------------------------------------------------------------------------
  // Prescaler taps: divide by 1, 4, 16, 64
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_cnt_reg <= 6'h00;
    else          pre_cnt_reg <= pre_cnt_reg + 6'h01;
  end

  wire [3:0] tap_tick = {pre_cnt_reg == `SCRS_PRE_DIV64,
                         pre_cnt_reg[3:0] == `SCRS_PRE_DIV16,
                         pre_cnt_reg[1:0] == `SCRS_PRE_DIV4,
                         1'b1};
  wire brg_in = tap_tick[brg_tap_select];
  wire tmr_in = tap_tick[prescaler_source_select];

  // --------------------------------------------------------------------------
  // Baud rate divider, integer or N + (16-K)/16
  // --------------------------------------------------------------------------
  wire [4:0] n_val    = (integer_divisor_field == 4'h0) ? `SCRS_N_ZERO_DIV
                                                        : {1'b0, integer_divisor_field};
  wire       n_frac_ok = (integer_divisor_field > 4'h1);        // N of 16 reads as zero
  wire       frac_on  = fractional_divide_enable & n_frac_ok;
  wire [4:0] period_m1 = n_val + {4'h0, extra_reg} - 5'h01;
  wire       div_wrap = brg_in & (div_cnt_reg >= period_m1);
  wire [4:0] frac_sum = {1'b0, frac_acc_reg} + (`SCRS_FRAC_BASE - {1'b0, fraction_field});

  // Accumulator carry stretches a period by one input tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg  <= 5'h00;
      frac_acc_reg <= 4'h0;
      extra_reg    <= 1'b0;
      brg_tick_reg <= 1'b0;
    end else begin
      brg_tick_reg <= div_wrap;
      if (div_wrap) begin
        div_cnt_reg  <= 5'h00;
        frac_acc_reg <= frac_on ? frac_sum[3:0] : 4'h0;
        extra_reg    <= frac_on & frac_sum[4];
      end else if (brg_in) begin
        div_cnt_reg  <= div_cnt_reg + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Half system clock and 8-bit timer trigger
  // --------------------------------------------------------------------------
  wire tmr_match = tmr_in & ((tmr_cnt_reg + 8'h01) == timer_reload_value);

  // Trigger toggles per reload, so one rising edge per two reloads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg    <= 1'b0;
      tmr_cnt_reg <= 8'h00;
      tab_out_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      if (tmr_match) begin
        tmr_cnt_reg <= 8'h00;
        tab_out_reg <= ~tab_out_reg;
      end else if (tmr_in) begin
        tmr_cnt_reg <= tmr_cnt_reg + 8'h01;
      end
    end
  end

  wire tab_tick = tmr_match & ~tab_out_reg;

  // UART bit-sample clock source; I/O mode never looks at this select
  wire bit_sample_clock =
    (uart_clock_source_select == `SCRS_SRC_DIVIDER)  ? brg_tick_reg :
    (uart_clock_source_select == `SCRS_SRC_HALF_SYS) ? half_reg :
    (uart_clock_source_select == `SCRS_SRC_TIMER)    ? tab_tick :
                                                       sck_rise;
  wire uart_on   = ~mode_io & rx_enable;
  wire uart_tick = uart_on & bit_sample_clock;

  // --------------------------------------------------------------------------
  // I/O interface shift clock
  // --------------------------------------------------------------------------
  wire io_on      = mode_io & rx_enable;
  wire io_drive   = io_on & ~clock_direction_bit;
  wire io_run     = io_drive & ~done_reg;                         // Stalls until data read
  wire io_int_rise = io_run & brg_tick_reg & ~sck_out_reg;
  wire io_ext_edge = clock_edge_select ? sck_fall : sck_rise;
  wire io_sample  = io_int_rise | (io_on & clock_direction_bit & io_ext_edge);

  // Driven clock idles high and toggles on each divider pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out_reg  <= 1'b1;
      sck_oe_n_reg <= 1'b1;
    end else begin
      sck_oe_n_reg <= ~io_drive;
      if (!io_drive) sck_out_reg <= 1'b1;
      else if (io_run & brg_tick_reg) sck_out_reg <= ~sck_out_reg;
    end
  end

  assign serial_clock_pin_o    = sck_out_reg;
  assign serial_clock_pin_oe_n = sck_oe_n_reg;

  // --------------------------------------------------------------------------
  // UART sampling and vote
  // --------------------------------------------------------------------------
  wire [3:0] cnt_inc  = rx_cnt_reg + 4'h1;
  wire       samp_hit = uart_tick & ((cnt_inc == `SCRS_SAMPLE_1ST) | (cnt_inc == `SCRS_SAMPLE_2ND));
  wire       vote_now = uart_tick & (cnt_inc == `SCRS_SAMPLE_3RD);
  wire       vote     = (samp_reg[1] & samp_reg[0]) | (samp_reg[1] & rxd) | (samp_reg[0] & rxd);

  // Receiver next state for both modes
  always_comb begin
    state_next   = state_reg;
    rx_cnt_next  = rx_cnt_reg;
    samp_next    = samp_reg;
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    frame_set    = 1'b0;
    frame_ferr   = 1'b0;
    if (uart_tick) rx_cnt_next = cnt_inc;
    if (samp_hit) samp_next = {samp_reg[0], rxd};
    case (state_reg)
      scrs_pkg::SCRS_RX_IDLE: begin
        if (uart_on & rxd_fall) begin
          rx_cnt_next = 4'h0;
          state_next  = scrs_pkg::SCRS_RX_START;
        end
      end
      scrs_pkg::SCRS_RX_START: begin
        if (vote_now) begin
          bit_cnt_next = 3'h0;
          state_next   = vote ? scrs_pkg::SCRS_RX_IDLE : scrs_pkg::SCRS_RX_DATA;
        end
      end
      scrs_pkg::SCRS_RX_DATA: begin
        if (vote_now) begin
          shift_next   = {vote, shift_reg[7:1]};
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `SCRS_LAST_BIT) state_next = scrs_pkg::SCRS_RX_STOP;
        end
      end
      scrs_pkg::SCRS_RX_STOP: begin
        if (vote_now) begin
          frame_set  = 1'b1;
          frame_ferr = ~vote;
          state_next = scrs_pkg::SCRS_RX_IDLE;
        end
      end
      default: state_next = scrs_pkg::SCRS_RX_IDLE;
    endcase
    if (!uart_on) state_next = scrs_pkg::SCRS_RX_IDLE;
    if (io_sample) begin
      shift_next   = {rxd, shift_reg[7:1]};
      bit_cnt_next = bit_cnt_reg + 3'h1;
      frame_set    = (bit_cnt_reg == `SCRS_LAST_BIT);
    end
  end

  // Receiver state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= scrs_pkg::SCRS_RX_IDLE;
      rx_cnt_reg  <= 4'h0;
      samp_reg    <= 2'h3;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else begin
      state_reg   <= state_next;
      rx_cnt_reg  <= rx_cnt_next;
      samp_reg    <= samp_next;
      shift_reg   <= shift_next;
      bit_cnt_reg <= (uart_on | io_on) ? bit_cnt_next : 3'h0;
    end
  end

  // Received byte and sticky flags; a new frame wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 8'h00;
      done_reg <= 1'b0;
      ferr_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end else begin
      if (frame_set & ~(done_reg & ~rd_data_clr)) data_reg <= shift_next;
      done_reg <= frame_set | (done_reg & ~rd_data_clr);
      ferr_reg <= frame_ferr | (ferr_reg & ~rd_stat_clr);
      ovr_reg  <= (frame_set & done_reg & ~rd_data_clr) | (ovr_reg & ~rd_stat_clr);
    end
  end

endmodule

// ### test/scrs_asserts.sv
// Port checks of the serial clock and receive front end.
// Assumes it is bound to scrs_top and sees only that module's ports.
`timescale 1ns/1ps
`include "scrs_defines.svh"

module scrs_asserts (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Shift clock pin
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_n
);
  // --------------------------------------
  // Shadow of the control word
  // --------------------------------------
  logic [7:0] ctrl_reg;
  logic       map_hit;
  logic       drive_mode;

  // Address decode and the mode that drives the clock pin
  assign map_hit    = paddr inside {`SCRS_ADDR_CTRL, `SCRS_ADDR_BRG, `SCRS_ADDR_TMR,
                                    `SCRS_ADDR_RXDATA, `SCRS_ADDR_STATUS};
  assign drive_mode = ctrl_reg[`SCRS_CTRL_MODE_IO] & ~ctrl_reg[`SCRS_CTRL_CLKDIR] & ctrl_reg[`SCRS_CTRL_RXEN];

  // Follow completed writes to the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SCRS_CTRL_RST;
    end else if (psel && penable && pready && pwrite && paddr == `SCRS_ADDR_CTRL) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // --------------------------------------
  // Assertions
  // --------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_LATENCY: assert property (psel && penable && $past(psel && !penable) |-> !pready ##1 pready)
    else $error("ready not on second access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_MAP: assert property (pready |-> pslverr == !map_hit)
    else $error("error flag does not match address map");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("unused read bits not zero");
  AST_CTRL_READBACK: assert property (pready && !pwrite && paddr == `SCRS_ADDR_CTRL |->
    prdata == {24'h0, ctrl_reg})
    else $error("control word readback wrong");
  AST_OE_DIRECTION: assert property ($stable(ctrl_reg) |-> serial_clock_pin_oe_n == !drive_mode)
    else $error("clock pin enable wrong for mode");
  AST_CLK_IDLE: assert property ($stable(ctrl_reg) && !drive_mode |-> serial_clock_pin_o)
    else $error("clock pin output not idle high");
endmodule

// ### test/scrs_peer.sv
// Model of the external serial peer on the data and clock pins.
// Assumes its tasks are started right after a rising edge of pclk.
`timescale 1ns/1ps

module scrs_peer (
  // Clock and shift clock from the device
  input  wire logic pclk,
  input  wire logic serial_clock_pin_o,
  // Lines driven toward the device
  output logic      receive_data_pin,
  output logic      serial_clock_pin_i
);
  logic prev_o;

  // Idle line and clock stand high
  initial begin
    receive_data_pin = 1'b1;
    serial_clock_pin_i = 1'b1;
  end

  // Shift clock one cycle back, for edge detection
  always_ff @(posedge pclk) begin
    prev_o <= serial_clock_pin_o;
  end

  // UART frame, LSB first, optional mid-bit upset and pin clock
  task automatic uart(input logic [7:0] b, input int cpb, input bit glitch, input bit pinclk);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < cpb; c++) begin
        @(posedge pclk);
        receive_data_pin <= (glitch && c == cpb / 2) ? ~f[i] : f[i];
        if (pinclk) serial_clock_pin_i <= (c % 8) >= 4;
      end
    end
    @(posedge pclk);
    serial_clock_pin_i <= 1'b1;
  endtask

  // Short low pulse that is no real start bit
  task automatic false_start(input int n);
    @(posedge pclk);
    receive_data_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    receive_data_pin <= 1'b1;
  endtask

  // Byte on the device's driven clock: change after a fall, held over the rise
  task automatic io_out(input logic [7:0] b);
    int r;
    r = 0;
    receive_data_pin <= b[0];
    for (int k = 0; k < 3000 && r < 8; k++) begin
      @(posedge pclk);
      if (!prev_o && serial_clock_pin_o) r++;
      if (prev_o && !serial_clock_pin_o && r > 0 && r < 8) receive_data_pin <= b[r];
    end
    receive_data_pin <= ~b[7];
  endtask

  // Byte on our own clock, period 20 cycles; data stable around both edges
  task automatic io_in(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      receive_data_pin <= b[i];
      repeat (5) @(posedge pclk);
      serial_clock_pin_i <= 1'b0;
      repeat (10) @(posedge pclk);
      serial_clock_pin_i <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    receive_data_pin <= ~b[7];
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench: APB master, serial peer model and port checker.
// Assumes scrs_top, scrs_peer and scrs_asserts are compiled beforehand.
`timescale 1ns/1ps
`include "scrs_defines.svh"

module testbench;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, sclk_i, sclk_o, sclk_oe_n;
  int          err_total = 0;
  int          n_checks  = 0;

  scrs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_data_pin(rxd), .serial_clock_pin_i(sclk_i), .serial_clock_pin_o(sclk_o),
    .serial_clock_pin_oe_n(sclk_oe_n));
  scrs_peer peer (.pclk(pclk), .serial_clock_pin_o(sclk_o), .receive_data_pin(rxd),
    .serial_clock_pin_i(sclk_i));

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // --------------------------------------
  // Shared tasks
  // --------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k == 20) begin
      err_total++;
      $display("FAIL %0t: bus transfer hung", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Poll the done flag a bounded number of times
  task automatic wait_done();
    logic [31:0] r;
    logic        e;
    int          k;
    for (k = 0; k < 50; k++) begin
      apb(1'b0, `SCRS_ADDR_STATUS, 32'h0, r, e);
      if (r[`SCRS_ST_DONE] === 1'b1) break;
    end
    if (k == 50) begin
      err_total++;
      $display("FAIL %0t: byte never arrived", $time);
      finish_test();
    end
  endtask

  // Rise-to-rise time of the driven shift clock, in pclk cycles
  task automatic meas(output int per);
    int   t, n;
    logic p;
    n = 0;
    t = 0;
    per = 0;
    p = sclk_o;
    for (int k = 0; k < 300 && n < 2; k++) begin
      @(posedge pclk);
      if (p === 1'b0 && sclk_o === 1'b1) begin
        if (n == 1) per = k - t;
        t = k;
        n++;
      end
      p = sclk_o;
    end
  endtask

  // --------------------------------------
  // Scenarios
  // --------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(`SCRS_ADDR_CTRL, 32'h0);
    rd(`SCRS_ADDR_BRG, 32'h1);
    rd(`SCRS_ADDR_TMR, 32'h1);
    wr(`SCRS_ADDR_CTRL, 32'hFFFF_FFFF);
    rd(`SCRS_ADDR_CTRL, 32'hFF);
    wr(`SCRS_ADDR_BRG, 32'hFFFF_FFFF);
    rd(`SCRS_ADDR_BRG, 32'h1FF);
    wr(`SCRS_ADDR_TMR, 32'hFFFF_FFFF);
    rd(`SCRS_ADDR_TMR, 32'h3FF);
    wr(`SCRS_ADDR_RXDATA, 32'hFFFF_FFFF);
    rd(`SCRS_ADDR_RXDATA, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    wr(`SCRS_ADDR_TMR, 32'h2);
  endtask

  // Every clock source, tap and divisor form; cycles per bit from the rules
  task automatic t_uart();
    logic [7:0] u_ctrl [9] = '{8'h80, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'h80, 8'h88, 8'h90, 8'h98};
    logic [8:0] u_brg  [9] = '{9'h001, 9'h000, 9'h001, 9'h001, 9'h001, 9'h1E4, 9'h001, 9'h001, 9'h001};
    int         u_cpb  [9] = '{16, 256, 64, 256, 1024, 66, 32, 64, 128};
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      d = 8'h5A ^ {i[3:0], i[3:0]};
      wr(`SCRS_ADDR_CTRL, {24'h0, u_ctrl[i]});
      wr(`SCRS_ADDR_BRG, {23'h0, u_brg[i]});
      peer.uart(d, u_cpb[i], i == 0, i == 8);
      wait_done();
      rd(`SCRS_ADDR_RXDATA, {24'h0, d});
    end
  endtask

  // Short low pulse is dropped; the next real frame still lands
  task automatic t_false_start();
    logic [31:0] r;
    logic        e;
    wr(`SCRS_ADDR_CTRL, 32'h80);
    wr(`SCRS_ADDR_BRG, 32'h1);
    peer.false_start(4);
    repeat (40) @(posedge pclk);
    apb(1'b0, `SCRS_ADDR_STATUS, 32'h0, r, e);
    chk({30'h0, r[`SCRS_ST_BUSY], r[`SCRS_ST_DONE]}, 32'h0);
    peer.uart(8'hC6, 16, 1'b0, 1'b0);
    wait_done();
    rd(`SCRS_ADDR_RXDATA, 32'hC6);
  endtask

  // Driven shift clock, also with the timer source selected
  task automatic t_io_out();
    logic [7:0] c [2] = '{8'h81, 8'h91};
    int         per;
    wr(`SCRS_ADDR_BRG, 32'h8);
    for (int j = 0; j < 2; j++) begin
      fork
        begin
          wr(`SCRS_ADDR_CTRL, {24'h0, c[j]});
          meas(per);
        end
        peer.io_out(8'h3B ^ {8{j[0]}});
      join
      chk(32'(per), 32'h10);
      wait_done();
      wr(`SCRS_ADDR_CTRL, 32'h0);
      rd(`SCRS_ADDR_RXDATA, {24'h0, 8'h3B ^ {8{j[0]}}});
    end
  endtask

  // External shift clock, rising then falling edge selected
  task automatic t_io_in();
    logic [7:0] c [2] = '{8'h83, 8'h87};
    for (int j = 0; j < 2; j++) begin
      wr(`SCRS_ADDR_CTRL, {24'h0, c[j]});
      peer.io_in(8'h96 ^ {4'h0, {4{j[0]}}});
      chk({31'h0, sclk_oe_n}, 32'h1);
      wait_done();
      rd(`SCRS_ADDR_RXDATA, {24'h0, 8'h96 ^ {4'h0, {4{j[0]}}}});
    end
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_uart();
    t_false_start();
    t_io_out();
    t_io_in();
    finish_test();
  end
endmodule

bind scrs_top scrs_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_n(serial_clock_pin_oe_n));
